// ==== hw/ebpm_bus_pins.sv ====
// Purpose: Maps external bus accesses onto strobes, address and data ports.
// Assumes: Core requests one access at a time and holds it until acc_done.
// Notes:   Data, address and segment pins share pad cells with generic I/O.
`timescale 1ns/1ns

// Operation
// - Read strobe on every external read
// - Plain-write mode strobes every write
// - Low-byte mode strobes low or 8-bit writes
// - Mode bit selects write strobe behaviour
// - Drive address latch enable output
// - Sample external-fetch pin during, after reset
// - Demux data on low or both bytes
// - Mux drives address then data on port
// - Address port kept after demux-to-mux switch
// - Segment lines A16..A21 on 6-bit port
// - Per-bit direction; inputs are high impedance
// - Multi-function port push/pull or open drain
// - Demux splits address/data; mux shares port
module ebpm_bus_pins
	import ebpm_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        reset_n,
	input  wire logic        ext_bus_en,
	input  wire logic [1:0]  bus_mode,
	input  wire logic        write_pin_mode_sel,
	input  wire logic        acc_req,
	input  wire logic        acc_write,
	input  wire logic [1:0]  acc_byte_en,
	input  wire logic [21:0] acc_addr,
	input  wire logic [15:0] acc_wdata,
	output logic             acc_done,
	output logic [15:0]      acc_rdata,
	output logic             read_strobe_n,
	output logic             low_byte_write_strobe_n,
	output logic             high_byte_write_strobe_n,
	output logic             addr_latch_en,
	input  wire logic        external_fetch_select_n,
	output logic             boot_external,
	input  wire logic [15:0] data_bus_port_in,
	output logic [15:0]      data_bus_port_out,
	output logic [15:0]      data_bus_port_oe_n,
	input  wire logic [15:0] addr_bus_port_in,
	output logic [15:0]      addr_bus_port_out,
	output logic [15:0]      addr_bus_port_oe_n,
	output logic [5:0]       segment_addr_port_out,
	output logic [5:0]       segment_addr_port_oe_n,
	input  wire logic [15:0] gp_data_out,
	input  wire logic [15:0] gp_data_dir,
	output logic [15:0]      gp_data_in,
	input  wire logic [15:0] gp_addr_out,
	input  wire logic [15:0] gp_addr_dir,
	output logic [15:0]      gp_addr_in,
	input  wire logic        seg_addr_en,
	input  wire logic [5:0]  gp_seg_out,
	input  wire logic [5:0]  gp_seg_dir,
	input  wire logic [11:0] mfp_out,
	input  wire logic [11:0] mfp_dir,
	input  wire logic [11:0] mfp_open_drain,
	input  wire logic [11:0] multi_function_port_in,
	output logic [11:0]      multi_function_port_out,
	output logic [11:0]      multi_function_port_oe_n,
	output logic [11:0]      mfp_in
);

	ebpm_state_t state_ff;
	ebpm_state_t nxt_state;
	logic [1:0]  cnt_ff;
	logic [1:0]  nxt_cnt;
	logic        demux_seen_ff;
	logic        fetch_s1_ff;
	logic        fetch_s2_ff;
	logic        fetch_hold_ff;
	logic [2:0]  rst_prev_ff;
	logic [15:0] rdata_ff;
	logic [15:0] dsync1_ff;
	logic [15:0] dsync2_ff;
	logic [15:0] async1_ff;
	logic [15:0] async2_ff;

	////////////////////////////////////////////////////////////////////////
	// Mode decode
	wire mode_mux   = bus_mode[1];
	wire mode_wide  = bus_mode[0];
	wire in_acc     = ext_bus_en && (state_ff != EBPM_IDLE);
	wire addr_phase = in_acc && (state_ff == EBPM_ADDR);
	wire strb_phase = in_acc && (state_ff == EBPM_STRB);
	wire rd_act     = strb_phase && !acc_write;
	wire wr_act     = strb_phase && acc_write;
	// Shared strobe: plain mode any write, low-byte mode low lane or 8-bit
	wire lo_wr_act  = wr_act && (!write_pin_mode_sel ||
	                  !mode_wide || acc_byte_en[0]);
	wire hi_wr_act  = wr_act && mode_wide && acc_byte_en[1];
	wire done_last  = (state_ff == EBPM_DONE) && cnt_ff[0];            // Read data now synced
	// Address port drives in demux and after leaving demux for mux
	wire addr_drv   = ext_bus_en && (!mode_mux || demux_seen_ff);

	// Data port values: mux puts address out first, then data
	wire [15:0] bus_data_val = addr_phase && mode_mux ? acc_addr[15:0]
	                                                  : acc_wdata;
	wire        drive_hi     = mode_wide || (addr_phase && mode_mux);
	wire        bus_drv      = addr_phase ? mode_mux : wr_act;
	wire [15:0] nxt_data_out = in_acc ? bus_data_val : gp_data_out;
	wire [15:0] nxt_data_oe  = in_acc ? ~({{8{bus_drv && drive_hi}}, {8{bus_drv}}})
	                                  : ~gp_data_dir;
	wire [15:0] nxt_addr_out = addr_drv ? acc_addr[15:0] : gp_addr_out;
	wire [15:0] nxt_addr_oe  = addr_drv ? 16'h0000 : ~gp_addr_dir;
	wire [5:0]  nxt_seg_out  = seg_addr_en ? acc_addr[21:16] : gp_seg_out;
	wire [5:0]  nxt_seg_oe   = seg_addr_en ? 6'h00 : ~gp_seg_dir;

	// Sequencer next state
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		case (state_ff)
			EBPM_IDLE: begin
				if (acc_req && ext_bus_en) begin
					nxt_state = EBPM_ADDR;
					nxt_cnt   = EBPM_ALE_CYC;
				end
			end
			EBPM_ADDR: begin
				nxt_cnt = cnt_ff - 2'h1;
				if (cnt_ff == 2'h1) begin
					nxt_state = EBPM_STRB;
					nxt_cnt   = EBPM_STB_CYC;
				end
			end
			EBPM_STRB: begin
				nxt_cnt = cnt_ff - 2'h1;
				if (cnt_ff == 2'h1) begin
					nxt_state = EBPM_DONE;
				end
			end
			EBPM_DONE: begin
				nxt_cnt   = 2'h1;                      // Two done cycles cover the sync delay
				nxt_state = cnt_ff[0] ? EBPM_IDLE : EBPM_DONE;
			end
			default:   nxt_state = EBPM_IDLE;
		endcase
	end

	// Sequencer and registered bus pins
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state_ff                 <= EBPM_IDLE;
			cnt_ff                   <= 2'h0;
			read_strobe_n            <= EBPM_RST_STB_N;
			low_byte_write_strobe_n  <= EBPM_RST_STB_N;
			high_byte_write_strobe_n <= EBPM_RST_STB_N;
			addr_latch_en            <= 1'b0;
			acc_done                 <= 1'b0;
		end else begin
			state_ff                 <= nxt_state;
			cnt_ff                   <= nxt_cnt;
			read_strobe_n            <= !rd_act;
			low_byte_write_strobe_n  <= !lo_wr_act;
			high_byte_write_strobe_n <= !hi_wr_act;
			addr_latch_en            <= addr_phase;
			acc_done                 <= done_last;
		end
	end

	// Port pads; registered so every pin comes from a flip-flop
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			data_bus_port_out      <= EBPM_RST_WORD;
			data_bus_port_oe_n     <= 16'hFFFF;
			addr_bus_port_out      <= EBPM_RST_WORD;
			addr_bus_port_oe_n     <= 16'hFFFF;
			segment_addr_port_out  <= EBPM_RST_SEG;
			segment_addr_port_oe_n <= 6'h3F;
		end else begin
			data_bus_port_out      <= nxt_data_out;
			data_bus_port_oe_n     <= nxt_data_oe;
			addr_bus_port_out      <= nxt_addr_out;
			addr_bus_port_oe_n     <= nxt_addr_oe;
			segment_addr_port_out  <= nxt_seg_out;
			segment_addr_port_oe_n <= nxt_seg_oe;
		end
	end

	// Remember a demux mode so the address port stays after a switch to mux
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			demux_seen_ff <= 1'b0;
		end else begin
			demux_seen_ff <= ext_bus_en && (demux_seen_ff || !mode_mux);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers; read data taken from the second stage in the last done cycle
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			dsync1_ff <= '0;
			dsync2_ff <= '0;
			async1_ff <= '0;
			async2_ff <= '0;
			rdata_ff  <= '0;
		end else begin
			dsync1_ff <= data_bus_port_in;
			dsync2_ff <= dsync1_ff;
			async1_ff <= addr_bus_port_in;
			async2_ff <= async1_ff;
			if (done_last && ext_bus_en && !acc_write) begin
				rdata_ff <= mode_wide ? dsync2_ff : {8'h00, dsync2_ff[7:0]};
			end
		end
	end
	assign acc_rdata  = rdata_ff;
	assign gp_data_in = dsync2_ff;
	assign gp_addr_in = async2_ff;

	////////////////////////////////////////////////////////////////////////
	// Boot select: sampled in reset and 3 cycles after, then held against pin moves
	always_ff @(posedge ref_clk) begin
		fetch_s1_ff <= external_fetch_select_n;
		fetch_s2_ff <= fetch_s1_ff;
		rst_prev_ff <= {rst_prev_ff[1:0], reset_n};
		if (rst_prev_ff != 3'b111) begin
			fetch_hold_ff <= !fetch_s2_ff;
		end
	end
	assign boot_external = fetch_hold_ff;

	////////////////////////////////////////////////////////////////////////
	// Multi-function port cells
	ebpm_port_cell #(
		.WIDTH (EBPM_MFP_W)
	) u_mfp (
		.ref_clk    (ref_clk),
		.reset_n    (reset_n),
		.out_val    (mfp_out),
		.dir_out    (mfp_dir),
		.open_drain (mfp_open_drain),
		.pin_in     (multi_function_port_in),
		.pin_out    (multi_function_port_out),
		.pin_oe_n   (multi_function_port_oe_n),
		.in_val     (mfp_in)
	);

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_read_strobe;
		@(posedge ref_clk) disable iff (!reset_n)
		(state_ff == EBPM_ADDR && ext_bus_en && !acc_write && cnt_ff == 2'h1)
			|=> ##1 !read_strobe_n [*2];
	endproperty
	a_read_strobe: assert property (p_read_strobe) else $error("no read strobe");
	property p_plain_write;
		@(posedge ref_clk) disable iff (!reset_n)
		(wr_act && !write_pin_mode_sel) |=> !low_byte_write_strobe_n;
	endproperty
	a_plain_write: assert property (p_plain_write) else $error("plain write missed");
	property p_lowbyte_write;
		@(posedge ref_clk) disable iff (!reset_n)
		(wr_act && write_pin_mode_sel && mode_wide && !acc_byte_en[0])
			|=> low_byte_write_strobe_n;
	endproperty
	a_lowbyte_write: assert property (p_lowbyte_write) else $error("low strobe on high byte");
	property p_ale_before_strobe;
		@(posedge ref_clk) disable iff (!reset_n)
		$fell(addr_latch_en) |-> !(read_strobe_n && low_byte_write_strobe_n
			&& high_byte_write_strobe_n);
	endproperty
	a_ale_before_strobe: assert property (p_ale_before_strobe) else $error("ale order");
	property p_idle_high;
		@(posedge ref_clk) disable iff (!reset_n)
		(state_ff == EBPM_IDLE) |=> (read_strobe_n && low_byte_write_strobe_n);
	endproperty
	a_idle_high: assert property (p_idle_high) else $error("strobe while idle");
	property p_demux_addr;
		@(posedge ref_clk) disable iff (!reset_n)
		(ext_bus_en && !mode_mux) |=> (addr_bus_port_oe_n == 16'h0000);
	endproperty
	a_demux_addr: assert property (p_demux_addr) else $error("addr port off");
	property p_mux_addr_out;
		@(posedge ref_clk) disable iff (!reset_n)
		(addr_phase && mode_mux) |=> (data_bus_port_out == $past(acc_addr[15:0]));
	endproperty
	a_mux_addr_out: assert property (p_mux_addr_out) else $error("mux addr wrong");
	property p_narrow_high_free;
		@(posedge ref_clk) disable iff (!reset_n)
		(wr_act && !mode_wide) |=> (data_bus_port_oe_n[15:8] == 8'hFF);
	endproperty
	a_narrow_high_free: assert property (p_narrow_high_free) else $error("high lane driven");
	property p_segment;
		@(posedge ref_clk) disable iff (!reset_n)
		seg_addr_en |=> (segment_addr_port_out == $past(acc_addr[21:16]));
	endproperty
	a_segment: assert property (p_segment) else $error("segment wrong");
	c_read:  cover property (@(posedge ref_clk) $fell(read_strobe_n));
	c_write: cover property (@(posedge ref_clk) $fell(high_byte_write_strobe_n));
	c_mux:   cover property (@(posedge ref_clk) addr_phase && mode_mux && demux_seen_ff);
endmodule : ebpm_bus_pins

// ==== hw/ebpm_pkg.sv ====
// Purpose: Shared constants and types for the external bus pin mapping block.
// Assumes: One clock domain (ref_clk, 100 MHz), synchronous active-low reset.
// Notes:   Bus mode and access encodings are used by the core and the testbench.
package ebpm_pkg;

	// Widths of the pin groups
	localparam int EBPM_DATA_W  = 16;
	localparam int EBPM_ADDR_W  = 16;
	localparam int EBPM_SEG_W   = 6;
	localparam int EBPM_MFP_W   = 12;
	localparam int EBPM_GP_W    = 16;

	// Values after reset
	localparam logic [15:0] EBPM_RST_WORD  = 16'h0000;
	localparam logic [5:0]  EBPM_RST_SEG   = 6'h00;
	localparam logic [11:0] EBPM_RST_MFP   = 12'h000;
	localparam logic        EBPM_RST_STB_N = 1'b1;

	// Cycle counts of one external access
	localparam logic [1:0] EBPM_ALE_CYC  = 2'h1;
	localparam logic [1:0] EBPM_STB_CYC  = 2'h2;

	// Bus mode: bit 1 = multiplexed, bit 0 = 16-bit data
	typedef enum logic [1:0] {
		EBPM_DEMUX8  = 2'b00,
		EBPM_DEMUX16 = 2'b01,
		EBPM_MUX8    = 2'b10,
		EBPM_MUX16   = 2'b11
	} ebpm_mode_t;

	// Access sequencer states, Gray along idle-address-strobe-done
	typedef enum logic [1:0] {
		EBPM_IDLE = 2'b00,
		EBPM_ADDR = 2'b01,
		EBPM_STRB = 2'b11,
		EBPM_DONE = 2'b10
	} ebpm_state_t;

endpackage : ebpm_pkg

// ==== hw/ebpm_port_cell.sv ====
// Purpose: General-purpose port bits with per-bit direction and drive type.
// Assumes: Pin inputs are asynchronous and pass two flip-flops here.
// Notes:   Output enables are active low, as the pad cells expect.
`timescale 1ns/1ns
module ebpm_port_cell
	import ebpm_pkg::*;
#(
	parameter int WIDTH = 12
) (
	input  wire logic             ref_clk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] out_val,
	input  wire logic [WIDTH-1:0] dir_out,
	input  wire logic [WIDTH-1:0] open_drain,
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] pin_out,
	output logic      [WIDTH-1:0] pin_oe_n,
	output logic      [WIDTH-1:0] in_val
);

	logic [WIDTH-1:0] sync1_ff;
	logic [WIDTH-1:0] sync2_ff;
	logic [WIDTH-1:0] nxt_oe_n;

	////////////////////////////////////////////////////////////////////////
	// Per-bit driver: input means high impedance, open drain only pulls low
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH; gi++) begin : g_bit
			assign nxt_oe_n[gi] = !dir_out[gi] ? 1'b1 :
			                      (open_drain[gi] ? out_val[gi] : 1'b0);
		end
	endgenerate

	// Registered pad drive so pins change cleanly on the clock
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			pin_out  <= '0;
			pin_oe_n <= '1;
		end else begin
			pin_out  <= out_val;
			pin_oe_n <= nxt_oe_n;
		end
	end

	// Two-stage synchroniser; only the second stage is read
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
		end else begin
			sync1_ff <= pin_in;
			sync2_ff <= sync1_ff;
		end
	end
	assign in_val = sync2_ff;

	////////////////////////////////////////////////////////////////////////
	// Checks
	property p_input_hiz;
		@(posedge ref_clk) disable iff (!reset_n)
		!dir_out[0] |=> pin_oe_n[0];
	endproperty
	a_input_hiz: assert property (p_input_hiz) else $error("input bit driven");

	property p_od_high_release;
		@(posedge ref_clk) disable iff (!reset_n)
		(dir_out[0] && open_drain[0] && out_val[0]) |=> pin_oe_n[0];
	endproperty
	a_od_high_release: assert property (p_od_high_release) else $error("od high driven");

endmodule : ebpm_port_cell

// ==== sim/ebpm_ext_mem.sv ====
// Purpose: External memory and address latch behind the bus pins.
// Assumes: Address in the low four bits selects one of 16 words.
// Notes:   Also resolves the data port wire against the block's pad drive.
`timescale 1ns/1ns
module ebpm_ext_mem
	import ebpm_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        mux_mode,
	input  wire logic        read_strobe_n,
	input  wire logic        low_byte_write_strobe_n,
	input  wire logic        high_byte_write_strobe_n,
	input  wire logic        addr_latch_en,
	input  wire logic [15:0] data_bus_port_out,
	input  wire logic [15:0] data_bus_port_oe_n,
	input  wire logic [15:0] addr_bus_port_out,
	output logic      [15:0] data_pin
);
	logic [15:0] mem_ff [0:15];
	logic [3:0]  addr_ff;
	logic [15:0] last_ff = 16'h0000;
	logic [15:0] mem_drive;

	////////////////////////////////////////////////////////////////////////////
	// Latch takes the address from whichever port carries it in this mode
	always_ff @(posedge ref_clk) begin
		if (addr_latch_en) begin
			addr_ff <= mux_mode ? data_bus_port_out[3:0] : addr_bus_port_out[3:0];
		end
		if (!low_byte_write_strobe_n) begin
			mem_ff[addr_ff][7:0] <= data_bus_port_out[7:0];
		end
		if (!high_byte_write_strobe_n) begin
			mem_ff[addr_ff][15:8] <= data_bus_port_out[15:15-7];
		end
		last_ff <= data_pin;
	end

	// Released bus toggles so a stale value can never pass for read data
	assign mem_drive = !read_strobe_n ? mem_ff[addr_ff] : ~last_ff;
	assign data_pin  = (~data_bus_port_oe_n & data_bus_port_out)
		| (data_bus_port_oe_n & mem_drive);
endmodule : ebpm_ext_mem

// ==== sim/tb_top.sv ====
// Purpose: Self-checking bench for the external bus pin mapping block.
// Assumes: Inputs change on the falling edge; the memory model answers reads.
// Notes:   Boot pin, generic I/O, refusal, all bus and write modes.
`timescale 1ns/1ns
module tb_top
	import ebpm_pkg::*;
;
	logic        ref_clk = 1'b0, reset_n, ext_bus_en, write_pin_mode_sel, acc_req, acc_write;
	logic        acc_done, read_strobe_n, low_byte_write_strobe_n, high_byte_write_strobe_n;
	logic        addr_latch_en, external_fetch_select_n, boot_external, seg_addr_en;
	logic [1:0]  bus_mode, acc_byte_en;
	logic [21:0] acc_addr, adr;
	logic [15:0] acc_wdata, acc_rdata, data_bus_port_in, data_bus_port_out, data_bus_port_oe_n;
	logic [15:0] addr_bus_port_in, addr_bus_port_out, addr_bus_port_oe_n, a_ext, rd;
	logic [15:0] gp_data_out, gp_data_dir, gp_data_in, gp_addr_out, gp_addr_dir, gp_addr_in;
	logic [5:0]  segment_addr_port_out, segment_addr_port_oe_n, gp_seg_out, gp_seg_dir;
	logic [11:0] mfp_out, mfp_dir, mfp_open_drain, multi_function_port_in, m_ext;
	logic [11:0] multi_function_port_out, multi_function_port_oe_n, mfp_in;
	logic [31:0] e;
	int          n_fail = 0, checks_done = 0, cyc = 0;
	ebpm_mode_t  modes [4] = '{EBPM_DEMUX16, EBPM_DEMUX8, EBPM_MUX8, EBPM_MUX16};

	////////////////////////////////////////////////////////////////////////////
	// Clock, and pad wires resolved against the outside level
	always #5 ref_clk = ~ref_clk;
	assign addr_bus_port_in = (~addr_bus_port_oe_n & addr_bus_port_out)
		| (addr_bus_port_oe_n & a_ext);
	assign multi_function_port_in = (~multi_function_port_oe_n & multi_function_port_out)
		| (multi_function_port_oe_n & m_ext);

	ebpm_bus_pins DUT (
		.ref_clk, .reset_n, .ext_bus_en, .bus_mode, .write_pin_mode_sel, .acc_req,
		.acc_write, .acc_byte_en, .acc_addr, .acc_wdata, .acc_done, .acc_rdata,
		.read_strobe_n, .low_byte_write_strobe_n, .high_byte_write_strobe_n,
		.addr_latch_en, .external_fetch_select_n, .boot_external, .data_bus_port_in,
		.data_bus_port_out, .data_bus_port_oe_n, .addr_bus_port_in, .addr_bus_port_out,
		.addr_bus_port_oe_n, .segment_addr_port_out, .segment_addr_port_oe_n,
		.gp_data_out, .gp_data_dir, .gp_data_in, .gp_addr_out, .gp_addr_dir, .gp_addr_in,
		.seg_addr_en, .gp_seg_out, .gp_seg_dir, .mfp_out, .mfp_dir, .mfp_open_drain,
		.multi_function_port_in, .multi_function_port_out, .multi_function_port_oe_n,
		.mfp_in
	);

	ebpm_ext_mem u_mem (
		.ref_clk, .mux_mode(bus_mode[1]), .read_strobe_n, .low_byte_write_strobe_n,
		.high_byte_write_strobe_n, .addr_latch_en, .data_bus_port_out,
		.data_bus_port_oe_n, .addr_bus_port_out, .data_pin(data_bus_port_in)
	);

	////////////////////////////////////////////////////////////////////////////
	// Compare and report
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : stop_test

	// Boot level is checked twice: once settled, once after the pin moves
	task automatic do_reset(input logic pin);
		@(negedge ref_clk);
		reset_n = 1'b0;
		external_fetch_select_n = pin;
		repeat (8) @(negedge ref_clk);
		reset_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		check(boot_external, !pin);
		external_fetch_select_n = ~pin;
		repeat (4) @(negedge ref_clk);
		check(boot_external, !pin);
	endtask : do_reset

	// One access; pins are watched every cycle until acc_done
	task automatic bus_acc(input logic wr, input logic [1:0] be, input logic [15:0] wd);
		int         k;
		logic [7:0] n_ale, n_rd, n_wl, n_wh, s2;
		logic [15:0] m;
		m = bus_mode[0] ? 16'hFFFF : 16'h00FF;
		s2 = {6'h00, EBPM_STB_CYC};
		{n_ale, n_rd, n_wl, n_wh} = '0;
		@(negedge ref_clk);
		{acc_req, acc_write, acc_byte_en, acc_addr, acc_wdata} = {1'b1, wr, be, adr, wd};
		for (k = 0; k < 20 && acc_done !== 1'b1; k++) begin
			@(negedge ref_clk);
			if (addr_latch_en === 1'b1) begin
				n_ale++;
				check(bus_mode[1] ? data_bus_port_out : addr_bus_port_out, adr[15:0]);
				check({addr_bus_port_oe_n, addr_bus_port_out}, adr[15:0]);
				check({segment_addr_port_oe_n, segment_addr_port_out}, adr[21:16]);
			end
			n_rd += (read_strobe_n === 1'b0);
			n_wl += (low_byte_write_strobe_n === 1'b0);
			n_wh += (high_byte_write_strobe_n === 1'b0);
			if (read_strobe_n === 1'b0) begin
				check(data_bus_port_oe_n & m, m);
			end
			if (wr && !(low_byte_write_strobe_n && high_byte_write_strobe_n)) begin
				check({data_bus_port_oe_n & m, data_bus_port_out & m}, wd & m);
			end
		end
		acc_req = 1'b0;
		rd = acc_rdata;
		check(acc_done, 1'b1);
		e = {8'h01, wr ? 8'h00 : s2, 8'h00, 8'h00};
		e[15:8] = (wr && (!write_pin_mode_sel || !bus_mode[0] || be[0])) ? s2 : 8'h00;
		e[7:0] = (wr && bus_mode[0] && be[1]) ? s2 : 8'h00;
		check({n_ale, n_rd, n_wl, n_wh}, e);
	endtask : bus_acc

	////////////////////////////////////////////////////////////////////////////
	// Cycle ceiling; the whole run needs well under 2000 cycles
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			stop_test();
		end
	end

	// Main sequence: generic I/O with the bus off, then every bus and write mode
	initial begin
		{reset_n, ext_bus_en, write_pin_mode_sel, acc_req, acc_write, seg_addr_en} = '0;
		{bus_mode, acc_byte_en, acc_addr, acc_wdata, external_fetch_select_n, adr} = '0;
		{gp_data_out, gp_data_dir, gp_addr_out, gp_addr_dir} = 64'hA5C3_0F0F_3C5A_FF00;
		{a_ext, gp_seg_out, gp_seg_dir} = {16'h96E1, 6'h3F, 6'h15};
		{mfp_out, mfp_dir, mfp_open_drain, m_ext} = 48'hA5C_FF0_0F0_FF3;
		do_reset(1'b0);
		acc_req = 1'b1;
		repeat (6) begin
			@(negedge ref_clk);
			check({acc_done, read_strobe_n, low_byte_write_strobe_n,
				high_byte_write_strobe_n, addr_latch_en}, 5'h0E);
		end
		acc_req = 1'b0;
		e = {~gp_data_dir, gp_data_out & gp_data_dir};
		check({data_bus_port_oe_n, data_bus_port_out & gp_data_dir}, e);
		e = {~gp_addr_dir, (gp_addr_dir & gp_addr_out) | (~gp_addr_dir & a_ext)};
		check({addr_bus_port_oe_n, gp_addr_in}, e);
		e = {~gp_seg_dir, gp_seg_out & gp_seg_dir};
		check({segment_addr_port_oe_n, segment_addr_port_out & gp_seg_dir}, e);
		e = {~mfp_dir | (mfp_open_drain & mfp_out), (mfp_dir & mfp_out) | (~mfp_dir & m_ext)};
		check({multi_function_port_oe_n, mfp_in}, e);
		check(gp_data_in & gp_data_dir, gp_data_out & gp_data_dir);
		check(multi_function_port_out & mfp_dir, mfp_out & mfp_dir);
		do_reset(1'b1);
		{ext_bus_en, seg_addr_en} = 2'b11;
		// Demux modes run first so the mux runs also test the kept address port
		for (int i = 0; i < 8; i++) begin
			bus_mode = modes[i / 2];
			write_pin_mode_sel = i[0];
			adr = {i[5:0] ^ 6'h2A, 12'h5C0, i[3:0]};
			bus_acc(1'b1, 2'b11, 16'hFFFF);
			bus_acc(1'b1, 2'b01, {8'h3C, 4'h6, i[3:0]});
			bus_acc(1'b1, 2'b10, {8'hD2, 4'h9, i[3:0]});
			bus_acc(1'b0, 2'b11, 16'h0000);
			e = {16'h0000, bus_mode[0] ? 8'hD2 : 8'h00, 4'h9, i[3:0]};
			e[7:4] = (!i[0] || !bus_mode[0]) ? 4'h9 : 4'h6;
			check(rd, e);
		end
		stop_test();
	end
endmodule : tb_top
